//--- rtl/seq_regs.svh
`ifndef SEQ_REGS_SVH
`define SEQ_REGS_SVH

// register byte offsets
`define A_CTRL       8'h00
`define A_STOP_INJ   8'h04
`define A_PREMAG_MAX 8'h08
`define A_ACCEL      8'h0C
`define A_DECEL1     8'h10
`define A_DECEL2     8'h14
`define A_LIFT_ILIM  8'h18
`define A_FREQ_REF   8'h1C
`define A_MAX_FREQ   8'h20
`define A_STATUS     8'h24

// control register fields
`define F_START_LO   0
`define F_START_HI   2
`define F_STOP_LO    4
`define F_STOP_HI    5
`define F_PREMAG_LO  8
`define F_PREMAG_HI  10
`define F_INHIBIT    12
`define F_LOW_NOISE  13
`define F_DECEL_SEL  14
`define CTRL_RESET   32'h0000_0011

// frequencies are in 0.01 Hz steps
`define BOOST_END_FREQ 16'h07D0
`define MAX_FREQ_RESET 16'h1388
`define NO_LIMIT       16'hFFFF

// one timer tick is one millisecond
`define CLK_HZ      10000000
`define TICK_US     1000
`define TICK_CYCLES (`CLK_HZ / 1000000 * `TICK_US)

`endif

//--- rtl/seq_pkg.sv
package seq_pkg;
    typedef enum logic [2:0] {
        st_idle, st_start_hold, st_search, st_run, st_decel, st_stop_inject
    } state_type;
    typedef logic [15:0] freq_type;
endpackage

//--- rtl/ms_timer_if.sv
`timescale 1ns/1ps
interface ms_timer_if #(parameter int W = 16);
    logic         load;
    logic [W-1:0] value;
    logic         tick;
    logic         busy;
    modport timer (input load, input value, input tick, output busy);
    modport user  (output load, output value, output tick, input busy);
endinterface

//--- rtl/ms_timer.sv
`timescale 1ns/1ps
module ms_timer #(parameter int W = 16) (
    // clock and reset
    input wire logic  aclk,
    input wire logic  aresetn,
    // control
    ms_timer_if.timer tif
);
    logic [W-1:0] cnt_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= '0;
        end else if (tif.load) begin
            cnt_reg <= tif.value;
        end else if (tif.tick && cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    assign tif.busy = (cnt_reg != '0);
endmodule

//--- rtl/drive_start_stop_sequencer.sv
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "seq_regs.svh"
// Behaviour
// - start mode 1: ramp output frequency up along acceleration time
// - start mode 2: search rotating motor frequency, resume modulation there
// - start mode 3: torque boost, applied only in the start phase
// - boost ends once frequency exceeds 20 Hz or equals reference
// - start mode 4: frequency search and start boost together
// - during boost switching stays at 4 kHz, low-noise option ignored
// - during boost current limit equals the lift current setting
// - stop mode 1: modulation stops, motor coasts freely
// - stop mode 2: ramp down with the selected deceleration time
// - after modulation stops, inject DC for the stop injection time
// - premag source 0 off, 1 to 5 pick a digital input
// - premag source 6: DC hold after start for maximum premag time
// - inhibit on: pending start ignored after reset, enable, location changes
// - inhibit off: pending start runs after any of those events
// - deceleration time spans maximum frequency down to zero
module drive_start_stop_sequencer #(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    // clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // axi4-lite slave
    input  wire logic [7:0]    awaddr,
    input  wire logic          awvalid,
    output logic               awready,
    input  wire logic [31:0]   wdata,
    input  wire logic [3:0]    wstrb,
    input  wire logic          wvalid,
    output logic               wready,
    output logic [1:0]         bresp,
    output logic               bvalid,
    input  wire logic          bready,
    input  wire logic [7:0]    araddr,
    input  wire logic          arvalid,
    output logic               arready,
    output logic [31:0]        rdata,
    output logic [1:0]         rresp,
    output logic               rvalid,
    input  wire logic          rready,
    // command inputs
    input  wire logic          start_cmd,
    input  wire logic          run_enable,
    input  wire logic [4:0]    digital_input_one_to_five,
    input  wire logic          fault_reset,
    input  wire logic          remote_sel,
    input  wire logic          external_location_two,
    // frequency search result from modulator
    input  wire logic          found_valid,
    input  wire seq_pkg::freq_type found_freq,
    // modulator side
    output logic               modulate,
    output logic               dc_inject,
    output logic               freq_search,
    output logic               boost_active,
    output logic               switch_8khz,
    output seq_pkg::freq_type  current_limit,
    output seq_pkg::freq_type  out_freq
);
    import seq_pkg::*;

    logic [31:0] ctrl_reg;
    logic [15:0] stop_injection_time, premag_max, accel_time;
    logic [15:0] decel_time_first, decel_time_second, lift_current_limit;
    freq_type    freq_ref, max_freq, freq_reg, target;
    state_type   state_reg;
    logic        aw_got, w_got, armed_reg, boost_phase;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [15:0] tick_cnt;
    logic        tick, start_q, run_en_q, remote_q, ext_q;
    logic        start_rise, inhibit_event, run_req;
    logic [23:0] acc_reg, acc_add;
    logic [15:0] ramp_time;
    logic        step;
    logic [2:0]  start_mode, premag_sel;
    logic [1:0]  stop_mode;
    logic        flying, boosting, premag_di;

    ms_timer_if #(.W(16)) tif ();
    ms_timer #(.W(16)) u_timer (.aclk(aclk), .aresetn(aresetn), .tif(tif));

    assign start_mode = ctrl_reg[`F_START_HI:`F_START_LO];
    assign stop_mode  = ctrl_reg[`F_STOP_HI:`F_STOP_LO];
    assign premag_sel = ctrl_reg[`F_PREMAG_HI:`F_PREMAG_LO];
    assign flying     = (start_mode == 3'h2) || (start_mode == 3'h4);
    assign boosting   = (start_mode == 3'h3) || (start_mode == 3'h4);

    // axi4-lite write: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            bvalid <= 1'b0;
            bresp <= 2'h0;
        end else begin
            if (awvalid && awready) begin
                aw_got <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_got <= 1'b1;
                w_data_q <= wdata;
            end
            if (aw_got && w_got && !bvalid) begin
                bvalid <= 1'b1;
                bresp <= (aw_addr_q > `A_MAX_FREQ || aw_addr_q[1:0] != 2'h0) ? 2'h2 : 2'h0;
                aw_got <= 1'b0;
                w_got <= 1'b0;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    assign awready = !aw_got && !bvalid;
    assign wready  = !w_got && !bvalid;

    // register file; only the low half of each timing word is used
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= `CTRL_RESET;
            stop_injection_time <= 16'h0000;
            premag_max <= 16'h0000;
            accel_time <= 16'h0000;
            decel_time_first <= 16'h0000;
            decel_time_second <= 16'h0000;
            lift_current_limit <= `NO_LIMIT;
            freq_ref <= 16'h0000;
            max_freq <= `MAX_FREQ_RESET;
        end else if (aw_got && w_got && !bvalid && wstrb != 4'h0) begin
            unique case (aw_addr_q)
                `A_CTRL:       ctrl_reg <= w_data_q;
                `A_STOP_INJ:   stop_injection_time <= w_data_q[15:0];
                `A_PREMAG_MAX: premag_max <= w_data_q[15:0];
                `A_ACCEL:      accel_time <= w_data_q[15:0];
                `A_DECEL1:     decel_time_first <= w_data_q[15:0];
                `A_DECEL2:     decel_time_second <= w_data_q[15:0];
                `A_LIFT_ILIM:  lift_current_limit <= w_data_q[15:0];
                `A_FREQ_REF:   freq_ref <= w_data_q[15:0];
                `A_MAX_FREQ:   max_freq <= w_data_q[15:0];
                default: ;
            endcase
        end
    end

    // axi4-lite read, answered one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= 2'h0;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= 2'h0;
            unique case (araddr)
                `A_CTRL:       rdata <= ctrl_reg;
                `A_STOP_INJ:   rdata <= {16'h0000, stop_injection_time};
                `A_PREMAG_MAX: rdata <= {16'h0000, premag_max};
                `A_ACCEL:      rdata <= {16'h0000, accel_time};
                `A_DECEL1:     rdata <= {16'h0000, decel_time_first};
                `A_DECEL2:     rdata <= {16'h0000, decel_time_second};
                `A_LIFT_ILIM:  rdata <= {16'h0000, lift_current_limit};
                `A_FREQ_REF:   rdata <= {16'h0000, freq_ref};
                `A_MAX_FREQ:   rdata <= {16'h0000, max_freq};
                `A_STATUS:     rdata <= {9'h000, state_reg, armed_reg, boost_phase,
                                         2'h0, freq_reg};
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= 2'h2;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    assign arready = !rvalid;

    // millisecond tick
    always_ff @(posedge aclk) begin
        if (!aresetn || tick) begin
            tick_cnt <= 16'h0000;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
        end
    end

    assign tick = (tick_cnt == 16'(TICK_CYCLES - 1));

    // start inhibit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_q <= 1'b0;
            run_en_q <= 1'b0;
            remote_q <= 1'b0;
            ext_q <= 1'b0;
        end else begin
            start_q <= start_cmd;
            run_en_q <= run_enable;
            remote_q <= remote_sel;
            ext_q <= external_location_two;
        end
    end

    assign start_rise = start_cmd && !start_q;
    assign inhibit_event = fault_reset || (run_enable && !run_en_q)
                         || (remote_sel != remote_q) || (external_location_two != ext_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            armed_reg <= 1'b1;
        end else if (start_rise) begin
            armed_reg <= 1'b1;
        end else if (inhibit_event && ctrl_reg[`F_INHIBIT]) begin
            armed_reg <= 1'b0;
        end
    end

    assign run_req = start_cmd && run_enable && armed_reg;

    // premagnetising from a digital input while stopped
    assign premag_di = (premag_sel >= 3'h1) && (premag_sel <= 3'h5)
                     && digital_input_one_to_five[premag_sel - 3'h1];

    // timer loads on entry to hold phases
    always_comb begin
        tif.load = 1'b0;
        tif.value = stop_injection_time;
        tif.tick = tick;
        if (state_reg == st_idle && run_req && premag_sel == 3'h6) begin
            tif.load = 1'b1;
            tif.value = premag_max;
        end else if ((state_reg == st_run && !run_req && stop_mode == 2'h1)
                     || (state_reg == st_decel && freq_reg == 16'h0000 && !run_req)) begin
            tif.load = 1'b1;
        end
    end

    // ramp generator, rate scaled so a full time covers max frequency to zero
    assign target = (state_reg == st_decel) ? 16'h0000
                  : (freq_ref > max_freq) ? max_freq : freq_ref;
    assign ramp_time = (freq_reg > target)
                     ? (ctrl_reg[`F_DECEL_SEL] ? decel_time_second : decel_time_first)
                     : accel_time;
    assign acc_add = acc_reg + (tick ? {8'h00, max_freq} : 24'h00_0000);
    assign step = acc_add >= {8'h00, ramp_time};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            freq_reg <= 16'h0000;
            acc_reg <= 24'h00_0000;
        end else if (state_reg == st_search && found_valid) begin
            freq_reg <= found_freq;
            acc_reg <= 24'h00_0000;
        end else if ((state_reg == st_run || state_reg == st_decel) && freq_reg != target) begin
            if (ramp_time == 16'h0000) begin
                freq_reg <= target;
                acc_reg <= 24'h00_0000;
            end else if (step) begin
                freq_reg <= (freq_reg > target) ? freq_reg - 1'b1 : freq_reg + 1'b1;
                acc_reg <= acc_add - {8'h00, ramp_time};
            end else begin
                acc_reg <= acc_add;
            end
        end else begin
            acc_reg <= 24'h00_0000;
            if (state_reg != st_run && state_reg != st_decel) begin
                freq_reg <= 16'h0000;
            end
        end
    end

    // sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= st_idle;
        end else begin
            unique case (state_reg)
                st_idle:
                    if (run_req) begin
                        if (premag_sel == 3'h6) begin
                            state_reg <= st_start_hold;
                        end else begin
                            state_reg <= flying ? st_search : st_run;
                        end
                    end
                st_start_hold:
                    if (!run_req) begin
                        state_reg <= st_idle;
                    end else if (!tif.busy) begin
                        state_reg <= flying ? st_search : st_run;
                    end
                st_search:
                    if (!run_req) begin
                        state_reg <= st_idle;
                    end else if (found_valid) begin
                        state_reg <= st_run;
                    end
                st_run:
                    if (!run_req) begin
                        state_reg <= (stop_mode == 2'h1) ? st_stop_inject : st_decel;
                    end
                st_decel:
                    if (run_req) begin
                        state_reg <= st_run;
                    end else if (freq_reg == 16'h0000) begin
                        state_reg <= st_stop_inject;
                    end
                st_stop_inject:
                    if (tif.busy == 1'b0 && !tif.load) begin
                        state_reg <= st_idle;
                    end
                default: state_reg <= st_idle;
            endcase
        end
    end

    // boost window is the start phase only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            boost_phase <= 1'b0;
        end else if (state_reg != st_run) begin
            boost_phase <= boosting;
        end else if (freq_reg > `BOOST_END_FREQ || freq_reg == freq_ref) begin
            boost_phase <= 1'b0;
        end
    end

    // registered modulator outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            modulate <= 1'b0;
            dc_inject <= 1'b0;
            freq_search <= 1'b0;
            boost_active <= 1'b0;
            switch_8khz <= 1'b0;
            current_limit <= `NO_LIMIT;
            out_freq <= 16'h0000;
        end else begin
            modulate <= (state_reg == st_run) || (state_reg == st_decel);
            dc_inject <= (state_reg == st_start_hold) || (state_reg == st_stop_inject)
                       || (state_reg == st_idle && premag_di);
            freq_search <= (state_reg == st_search);
            boost_active <= boost_phase && state_reg == st_run;
            switch_8khz <= ctrl_reg[`F_LOW_NOISE]
                         && !(boost_phase && state_reg == st_run);
            current_limit <= (boost_phase && state_reg == st_run)
                           ? lift_current_limit : `NO_LIMIT;
            out_freq <= freq_reg;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_stop_free_run_stop;
        state_reg == st_run && !run_req && stop_mode == 2'h1;
    endsequence
    sequence s_injecting;
        state_reg == st_stop_inject ##1 dc_inject && !modulate;
    endsequence

    property p_ramp_start;
        state_reg == st_idle && run_req && premag_sel == 3'h0 && start_mode == 3'h1
            |=> state_reg == st_run;
    endproperty
    a_ramp_start: assert property (p_ramp_start) else $error("ramp start not taken");

    property p_flying;
        state_reg == st_idle && run_req && premag_sel == 3'h0 && flying
            |=> state_reg == st_search ##1 freq_search;
    endproperty
    a_flying: assert property (p_flying) else $error("search not started");

    property p_boost_start_only;
        boost_active |-> $past(state_reg) == st_run && boosting;
    endproperty
    a_boost_start_only: assert property (p_boost_start_only) else $error("boost outside start");

    property p_boost_end;
        state_reg == st_run && freq_reg > `BOOST_END_FREQ |=> ##1 !boost_active;
    endproperty
    a_boost_end: assert property (p_boost_end) else $error("boost above 20 Hz");

    property p_fixed_switch;
        boost_active |-> !switch_8khz && current_limit == $past(lift_current_limit);
    endproperty
    a_fixed_switch: assert property (p_fixed_switch) else $error("boost switch or limit");

    property p_free_run_stop;
        s_stop_free_run_stop |=> s_injecting;
    endproperty
    a_free_run_stop: assert property (p_free_run_stop) else $error("free_run_stop stop failed");

    property p_ramp_stop;
        state_reg == st_run && !run_req && stop_mode == 2'h2 |=> state_reg == st_decel;
    endproperty
    a_ramp_stop: assert property (p_ramp_stop) else $error("ramp stop failed");

    property p_premag_off;
        premag_sel == 3'h0 && state_reg == st_idle |=> !dc_inject;
    endproperty
    a_premag_off: assert property (p_premag_off) else $error("premag when disabled");

    property p_inhibit;
        ctrl_reg[`F_INHIBIT] && inhibit_event && !start_rise |=> !armed_reg;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("start not inhibited");
endmodule

//--- tb/mod_model.sv
`timescale 1ns/1ps
// modulator stand-in: answers a frequency search after DLY cycles
module mod_model #(
    parameter int       DLY = 5,
    parameter logic [15:0] F = 16'h0100
) (
    // clock
    input  wire logic        aclk,
    // search handshake
    input  wire logic        freq_search,
    output logic             found_valid,
    output seq_pkg::freq_type found_freq
);
    import seq_pkg::*;
    int c = 0;
    initial found_valid = 1'b0;
    initial found_freq = 16'h5A5A;
    // outside a valid answer the result bus toggles so no stale value passes
    always @(posedge aclk) begin
        c <= freq_search ? ((c < DLY) ? c + 1 : c) : 0;
        found_valid <= freq_search && c == DLY;
        found_freq <= (freq_search && c == DLY) ? F : ~found_freq;
    end
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
`include "seq_regs.svh"
`define CK(s, e, a) begin checked++; if ((a) !== (e)) begin bad_count++; \
    $display("Error %s exp %0h got %0h", s, e, a); end end
`define WT(c) begin n = 0; while (!(c) && n < 3000) begin @(posedge aclk); #1; n++; end \
    if (n >= 3000) tmo(); end
module tb;
    import seq_pkg::*;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic        arvalid = 0, rready = 0, start_cmd = 0, run_enable = 0;
    logic        fault_reset = 0, remote_sel = 0, external_location_two = 0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd_data;
    logic [3:0]  wstrb = 4'hF;
    logic [4:0]  digital_input_one_to_five = 5'h00;
    logic [1:0]  bresp, rresp, rd_resp, wr_resp;
    logic        aw_t, w_t, b_t, r_t;
    logic        awready, wready, bvalid, arready, rvalid, found_valid;
    logic        modulate, dc_inject, freq_search, boost_active, switch_8khz;
    freq_type    found_freq, current_limit, out_freq;
    int          bad_count = 0, checked = 0, n;
    drive_start_stop_sequencer #(.TICK_CYCLES(10)) dut (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .start_cmd(start_cmd), .run_enable(run_enable),
        .digital_input_one_to_five(digital_input_one_to_five),
        .fault_reset(fault_reset), .remote_sel(remote_sel),
        .external_location_two(external_location_two),
        .found_valid(found_valid), .found_freq(found_freq),
        .modulate(modulate), .dc_inject(dc_inject), .freq_search(freq_search),
        .boost_active(boost_active), .switch_8khz(switch_8khz),
        .current_limit(current_limit), .out_freq(out_freq));
    mod_model #(.DLY(5), .F(16'h0100)) model (.aclk(aclk), .freq_search(freq_search),
        .found_valid(found_valid), .found_freq(found_freq));
    initial forever #50 aclk = ~aclk;
    task end_sim;
        if (bad_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task tmo;
        bad_count++;
        $display("Error wait timeout");
        end_sim();
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        n = 0;
        do begin
            #1;
            aw_t = awvalid && awready;
            w_t = wvalid && wready;
            b_t = bvalid && bready;
            wr_resp = bresp;
            @(posedge aclk);
            n++;
            if (aw_t) awvalid <= 0;
            if (w_t) wvalid <= 0;
        end while (!b_t && n < 100);
        bready <= 0;
        if (n >= 100) tmo();
    endtask
    task rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        n = 0;
        do begin
            #1;
            r_t = rvalid && rready;
            if (r_t) begin
                rd_data = rdata;
                rd_resp = rresp;
            end
            if (arvalid && arready) begin
                @(posedge aclk);
                arvalid <= 0;
            end else begin
                @(posedge aclk);
            end
            n++;
        end while (!r_t && n < 100);
        rready <= 0;
        if (n >= 100) tmo();
    endtask
    task go;
        @(posedge aclk);
        start_cmd <= 1;
        run_enable <= 1;
    endtask
    task stop_wait;
        @(posedge aclk);
        start_cmd <= 0;
        `WT(!modulate && !dc_inject)
    endtask
    task t_regs;
        rd(`A_CTRL);
        `CK("ctrl", 32'h0000_0011, rd_data)
        rd(`A_MAX_FREQ);
        `CK("max_freq", 32'h0000_1388, rd_data)
        rd(8'h28);
        `CK("unmapped", 2'h2, rd_resp)
        wr(`A_STATUS, 32'h0);
        `CK("wr_err", 2'h2, wr_resp)
    endtask
    task t_free_run_stop;
        wr(`A_FREQ_REF, 32'h0100);
        wr(`A_ACCEL, 32'h2);
        wr(`A_STOP_INJ, 32'h3);
        go();
        `WT(modulate)
        `CK("ramp", 1'b1, out_freq < 16'h0100)
        `WT(out_freq == 16'h0100)
        @(posedge aclk);
        start_cmd <= 0;
        `WT(!modulate)
        `CK("brake", 1'b1, dc_inject)
        `WT(!dc_inject)
        `CK("inj_len", 1'b1, n >= 20 && n <= 32)
    endtask
    task t_decel;
        wr(`A_CTRL, 32'h0000_4021);
        wr(`A_DECEL1, 32'h1);
        wr(`A_DECEL2, 32'h3E8);
        wr(`A_STOP_INJ, 32'h1);
        go();
        `WT(modulate && out_freq == 16'h0100)
        @(posedge aclk);
        start_cmd <= 0;
        `WT(!modulate)
        `CK("decel_len", 1'b1, n >= 500 && n <= 530)
        `CK("hold", 1'b1, dc_inject)
        `WT(!dc_inject)
    endtask
    task t_boost;
        wr(`A_CTRL, 32'h0000_2013);
        wr(`A_LIFT_ILIM, 32'h0123);
        wr(`A_ACCEL, 32'h4);
        for (int i = 0; i < 2; i++) begin
            wr(`A_FREQ_REF, (i == 1) ? 32'h0500 : 32'h1000);
            go();
            `WT(boost_active)
            `CK("ilim", 16'h0123, current_limit)
            `CK("sw_boost", 1'b0, switch_8khz)
            `WT(!boost_active)
            `CK("end", 1'b1, (i == 1) ? out_freq == 16'h0500 :
                (out_freq > 16'h07D0 && out_freq < 16'h1000))
            @(posedge aclk);
            #1;
            `CK("sw_after", 1'b1, switch_8khz)
            `CK("ilim_after", 16'hFFFF, current_limit)
            stop_wait();
        end
    endtask
    task t_fly;
        wr(`A_CTRL, 32'h0000_0014);
        wr(`A_FREQ_REF, 32'h1000);
        wr(`A_ACCEL, 32'h64);
        go();
        `WT(freq_search)
        `CK("no_mod", 1'b0, modulate)
        `WT(modulate)
        `CK("catch", 1'b1, out_freq >= 16'h0100 && out_freq <= 16'h0140)
        `WT(boost_active)
        `CK("lift", 1'b1, boost_active)
        stop_wait();
    endtask
    task t_premag;
        wr(`A_CTRL, 32'h0000_0111);
        @(posedge aclk);
        digital_input_one_to_five <= 5'h01;
        `WT(dc_inject)
        `CK("premag_di", 1'b1, dc_inject)
        @(posedge aclk);
        digital_input_one_to_five <= 5'h02;
        repeat (5) @(posedge aclk);
        #1;
        `CK("premag_other", 1'b0, dc_inject)
        wr(`A_CTRL, 32'h0000_0611);
        wr(`A_PREMAG_MAX, 32'h2);
        digital_input_one_to_five <= 5'h00;
        go();
        `WT(dc_inject)
        `CK("hold_mod", 1'b0, modulate)
        `WT(!dc_inject)
        `CK("hold_len", 1'b1, n >= 11 && n <= 22)
        `WT(modulate)
        stop_wait();
    endtask
    task t_inhibit;
        for (int i = 0; i < 2; i++) begin
            wr(`A_CTRL, (i == 1) ? 32'h0000_0011 : 32'h0000_1011);
            run_enable <= 0;
            @(posedge aclk);
            start_cmd <= 1;
            @(posedge aclk);
            fault_reset <= 1;
            @(posedge aclk);
            fault_reset <= 0;
            remote_sel <= ~remote_sel;
            external_location_two <= ~external_location_two;
            @(posedge aclk);
            run_enable <= 1;
            repeat (20) @(posedge aclk);
            #1;
            `CK("pending", (i == 1), modulate)
            if (i == 0) begin
                @(posedge aclk);
                start_cmd <= 0;
                @(posedge aclk);
                start_cmd <= 1;
                `WT(modulate)
                `CK("fresh", 1'b1, modulate)
            end
            stop_wait();
        end
    endtask
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        t_regs();
        t_free_run_stop();
        t_decel();
        t_boost();
        t_fly();
        t_premag();
        t_inhibit();
        end_sim();
    end
endmodule
